/* logic/fscr_top.sv */
// Configuration register bank for the floppy tail and both serial ports.
// Assumes an APB master on i_clk_sys and host I/O reads synchronous to the same clock.
`timescale 1ns/10ps
module fscr_top import fscr_pkg::*; (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [APB_AW-1:0] i_paddr,
  input wire logic [DATA_W-1:0] i_pwdata,
  output logic o_pready,
  output logic [DATA_W-1:0] o_prdata,
  output logic o_pslverr,
  // Host I/O read probe
  input wire logic i_io_rd,
  input wire logic [15:0] i_io_addr,
  output logic o_io_claim,
  output logic [7:0] o_io_rdata,
  // Decoded configuration
  output fscr_uart_cfg_t [1:0] o_uart_cfg,
  output fscr_floppy_cfg_t o_floppy_cfg
);

  logic [7:0] ldn_r;
  logic [7:0] mode_r;
  logic [1:0][7:0] uact_r;
  logic [1:0][7:0] urchk_r;
  logic [1:0][7:0] ubase_hi_r;
  logic [1:0][7:0] ubase_lo_r;
  logic [1:0][7:0] uirq_r;
  logic [7:0] uspec_r;
  logic [7:0] fdma_r;
  logic [7:0] fspec_r;
  logic [DATA_W-1:0] prdata_r;
  logic pslverr_r;
  logic io_claim_r;
  logic [7:0] io_rdata_r;
  fscr_uart_cfg_t [1:0] ucfg_r;
  fscr_floppy_cfg_t fcfg_r;

  logic [IDX_W-1:0] idx;
  logic aligned;
  logic mb_mode;
  logic sel_floppy;
  logic sel_uart;
  logic un;
  logic [7:0] rd_nxt;
  logic hit_nxt;
  logic setup;
  logic wr_en;
  logic [7:0] wd;
  logic [1:0][15:0] ubase;
  logic [1:0] io_hit;

  // Index decode and device routing
  assign idx = i_paddr[IDX_LSB +: IDX_W];
  assign aligned = (i_paddr[IDX_LSB-1:0] == '0);
  assign mb_mode = mode_r[MODE_MB_BIT];
  assign sel_floppy = (ldn_r == LDN_FLOPPY);
  assign sel_uart = (ldn_r == LDN_UART1) || (ldn_r == LDN_UART2);
  assign un = (ldn_r == LDN_UART2);
  assign wd = i_pwdata[7:0];
  assign setup = i_psel && !i_penable;
  assign wr_en = i_psel && i_penable && i_pwrite && aligned && hit_nxt;
  assign o_pready = 1'b1;

  // Full 16-bit base address of each serial port
  always_comb begin
    for (int n = 0; n < 2; n++) begin
      ubase[n] = {ubase_hi_r[n], ubase_lo_r[n]};
    end
  end

  // Read mux and mapped-address flag
  always_comb begin
    rd_nxt = RST_ZERO;
    hit_nxt = 1'b1;
    if (idx == IDX_LDN) begin
      rd_nxt = ldn_r;
    end else if (idx == IDX_MODE) begin
      rd_nxt = mode_r;
    end else if (sel_floppy && idx == IDX_IRQ_TYPE) begin
      rd_nxt = IRQ_TYPE_EDGE;
    end else if (sel_floppy && idx == IDX_DMA) begin
      rd_nxt = fdma_r;
    end else if (sel_floppy && idx == IDX_SPECIAL) begin
      rd_nxt = mb_mode ? fspec_r : RST_ZERO;
    end else if (sel_uart && idx == IDX_ACT) begin
      rd_nxt = uact_r[un];
    end else if (sel_uart && idx == IDX_RCHK) begin
      rd_nxt = urchk_r[un];
    end else if (sel_uart && idx == IDX_BASE_HI) begin
      rd_nxt = ubase_hi_r[un];
    end else if (sel_uart && idx == IDX_BASE_LO) begin
      rd_nxt = ubase_lo_r[un];
    end else if (sel_uart && idx == IDX_IRQ_LVL) begin
      rd_nxt = uirq_r[un];
    end else if (sel_uart && idx == IDX_IRQ_TYPE) begin
      rd_nxt = IRQ_TYPE_EDGE;
    end else if (sel_uart && !un && idx == IDX_SPECIAL) begin
      rd_nxt = mb_mode ? uspec_r : RST_ZERO;
    end else begin
      hit_nxt = 1'b0;
    end
  end

  // Read data and error captured in the setup cycle
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      prdata_r <= '0;
      pslverr_r <= 1'b0;
    end else if (setup) begin
      prdata_r <= (!i_pwrite && aligned && hit_nxt) ? DATA_W'(rd_nxt) : '0;
      pslverr_r <= !(aligned && hit_nxt);
    end
  end
  assign o_prdata = prdata_r;
  assign o_pslverr = pslverr_r;

  // Global device selector and operating mode
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      ldn_r <= RST_ZERO;
      mode_r <= RST_ZERO;
    end else if (wr_en && idx == IDX_LDN) begin
      ldn_r <= wd;
    end else if (wr_en && idx == IDX_MODE) begin
      mode_r <= wd & MASK_MODE;
    end
  end

  // Serial port register sets, addressed by the selected device
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      uact_r <= {RST_ZERO, RST_ZERO};
      urchk_r <= {RST_ZERO, RST_ZERO};
      ubase_hi_r <= {RST_U2_BASE_HI, RST_U1_BASE_HI};
      ubase_lo_r <= {RST_BASE_LO, RST_BASE_LO};
      uirq_r <= {RST_U2_IRQ, RST_U1_IRQ};
    end else if (wr_en && sel_uart) begin
      if (idx == IDX_ACT) begin
        uact_r[un] <= wd & MASK_ACT;
      end else if (idx == IDX_RCHK) begin
        urchk_r[un] <= wd & MASK_RCHK;
      end else if (idx == IDX_BASE_HI) begin
        ubase_hi_r[un] <= wd & MASK_BASE_HI;
      end else if (idx == IDX_BASE_LO) begin
        ubase_lo_r[un] <= wd & MASK_BASE_LO;
      end else if (idx == IDX_IRQ_LVL) begin
        uirq_r[un] <= wd & MASK_IRQ_LVL;
      end
    end
  end

  // Special registers, writable only in motherboard mode
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      uspec_r <= RST_ZERO;
      fspec_r <= RST_ZERO;
    end else if (wr_en && mb_mode && idx == IDX_SPECIAL) begin
      if (sel_uart && !un) begin
        uspec_r <= wd & MASK_USPEC;
      end else if (sel_floppy) begin
        fspec_r <= wd & MASK_FSPEC;
      end
    end
  end

  // Floppy DMA channel field
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      fdma_r <= RST_DMA;
    end else if (wr_en && sel_floppy && idx == IDX_DMA) begin
      fdma_r <= wd & MASK_DMA;
    end
  end

  // Range check hit per port, ISA mode only
  always_comb begin
    for (int n = 0; n < 2; n++) begin
      io_hit[n] = urchk_r[n][RCHK_EN_BIT] && !mb_mode
        && (i_io_addr[15:UART_SPAN_BITS] == ubase[n][15:UART_SPAN_BITS]);
    end
  end

  // Range check answer, one cycle after the read
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      io_claim_r <= 1'b0;
      io_rdata_r <= RST_ZERO;
    end else begin
      io_claim_r <= i_io_rd && (io_hit != '0);
      if (i_io_rd && io_hit[0]) begin
        io_rdata_r <= urchk_r[0][RCHK_PAT_BIT] ? RCHK_ANS_SET : RCHK_ANS_CLR;
      end else if (i_io_rd && io_hit[1]) begin
        io_rdata_r <= urchk_r[1][RCHK_PAT_BIT] ? RCHK_ANS_SET : RCHK_ANS_CLR;
      end else begin
        io_rdata_r <= RST_ZERO;
      end
    end
  end
  assign o_io_claim = io_claim_r;
  assign o_io_rdata = io_rdata_r;

  // Interrupt level to one-hot request line
  function automatic logic [15:0] irq_decode(input logic [3:0] lvl);
    logic [15:0] line;
    line = '0;
    if (lvl >= IRQ_FIRST && lvl <= IRQ_LAST) begin
      line[lvl] = 1'b1;
    end
    return line;
  endfunction

  // Serial port settings toward the function units
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      ucfg_r <= '0;
    end else begin
      for (int n = 0; n < 2; n++) begin
        ucfg_r[n].enable <= uact_r[n][ACT_EN_BIT];
        ucfg_r[n].base <= ubase[n];
        ucfg_r[n].irq_line <= irq_decode(uirq_r[n][3:0]);
      end
      ucfg_r[0].irq_share <= mb_mode && uspec_r[USPEC_SHARE];
      ucfg_r[0].midi <= mb_mode && uspec_r[USPEC_MIDI];
      ucfg_r[1].irq_share <= 1'b0;
      ucfg_r[1].midi <= 1'b0;
    end
  end
  assign o_uart_cfg = ucfg_r;

  // Floppy settings toward the function unit
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      fcfg_r <= '0;
    end else begin
      fcfg_r.dma_req <= (fdma_r[2:0] <= DMA_LAST) ? 4'(4'h1 << fdma_r[1:0]) : 4'h0;
      fcfg_r.irq_share <= mb_mode && fspec_r[FSPEC_SHARE];
      fcfg_r.swap_ab <= mb_mode && fspec_r[FSPEC_SWAP];
      fcfg_r.three_mode <= mb_mode && fspec_r[FSPEC_3MODE];
      fcfg_r.wr_protect <= mb_mode && fspec_r[FSPEC_WP];
    end
  end
  assign o_floppy_cfg = fcfg_r;

  // Checks on the register bank
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rstn);

  chk_ldn_route: assert property (
    wr_en && idx == IDX_ACT && ldn_r == LDN_UART2 |=> uact_r[1] == ($past(wd) & MASK_ACT) && $stable(uact_r[0]))
    else $error("activate write went to the wrong port");

  chk_irq_type_fixed: assert property (
    setup && !i_pwrite && aligned && idx == IDX_IRQ_TYPE && (sel_floppy || sel_uart) |=> o_prdata == 32'h0000_0002)
    else $error("interrupt type not read as edge");

  chk_dma_none: assert property (
    (i_rstn && fdma_r[2:0] > DMA_LAST) [*2] |-> o_floppy_cfg.dma_req == 4'h0)
    else $error("dma request for invalid or none selection");

  chk_dma_onehot: assert property (
    (i_rstn && fdma_r == 8'h02) [*2] |-> o_floppy_cfg.dma_req == 4'h4)
    else $error("dma channel two not decoded");

  chk_floppy_swap: assert property (
    mb_mode && fspec_r[FSPEC_SWAP] |=> o_floppy_cfg.swap_ab)
    else $error("drive swap not applied");

  chk_floppy_share: assert property (
    mb_mode && fspec_r[FSPEC_SHARE] |=> o_floppy_cfg.irq_share)
    else $error("floppy interrupt sharing not applied");

  chk_floppy_modes: assert property (
    i_rstn |=> o_floppy_cfg.wr_protect == ($past(mb_mode) && $past(fspec_r[FSPEC_WP]))
      && o_floppy_cfg.three_mode == ($past(mb_mode) && $past(fspec_r[FSPEC_3MODE])))
    else $error("floppy mode bits wrong");

  chk_act_reserved: assert property (
    uact_r[0][7:1] == 7'h0 && uact_r[1][7:1] == 7'h0 && urchk_r[0][7:2] == 6'h0)
    else $error("reserved bits held a value");

  chk_range_answer: assert property (
    i_io_rd && io_hit[0] && urchk_r[0][0] |=> o_io_claim && o_io_rdata == 8'h55)
    else $error("range check answer wrong");

  chk_range_isa_only: assert property (
    mb_mode |=> !o_io_claim)
    else $error("range check active in motherboard mode");

  chk_base_high_ro: assert property (
    setup && !i_pwrite && idx == IDX_BASE_HI && sel_uart |=> o_prdata[7:4] == 4'h0)
    else $error("base high upper nibble not zero");

  chk_base_low_align: assert property (
    o_uart_cfg[0].base[2:0] == 3'h0 && o_uart_cfg[1].base[2:0] == 3'h0)
    else $error("serial base not eight-byte aligned");

  chk_irq_decode: assert property (
    (i_rstn && uirq_r[0] == 8'h0b) [*2] |-> o_uart_cfg[0].irq_line == 16'h0800)
    else $error("level eleven not decoded");

  chk_irq_mid: assert property (
    (i_rstn && uirq_r[1] == 8'h07) [*2] |-> o_uart_cfg[1].irq_line == 16'h0080)
    else $error("level seven not decoded");

  chk_uart1_spec: assert property (
    (i_rstn && mb_mode && uspec_r == 8'h02) [*2] |-> o_uart_cfg[0].irq_share && !o_uart_cfg[0].midi)
    else $error("serial special bits not applied");

  chk_spec_mb_only: assert property (
    wr_en && idx == IDX_SPECIAL && !mb_mode |=> $stable(fspec_r) && $stable(uspec_r))
    else $error("special register written in ISA mode");

  // Register read-back shape
  chk_act_read: assert property (
    setup && !i_pwrite && idx == IDX_ACT && sel_uart |=> o_prdata[7:1] == 7'h0)
    else $error("activate reserved bits read nonzero");

  chk_base_low_read: assert property (
    setup && !i_pwrite && idx == IDX_BASE_LO && sel_uart |=> o_prdata[2:0] == 3'h0)
    else $error("base low alignment bits read nonzero");

  chk_irq_lvl_upper: assert property (
    setup && !i_pwrite && idx == IDX_IRQ_LVL && sel_uart |=> o_prdata[7:4] == 4'h0)
    else $error("interrupt level upper nibble nonzero");

  chk_dma_read: assert property (
    setup && !i_pwrite && idx == IDX_DMA && sel_floppy |=> o_prdata[7:3] == 5'h0)
    else $error("dma select reserved bits nonzero");

  chk_spec_isa_read: assert property (
    setup && !i_pwrite && aligned && idx == IDX_SPECIAL && !mb_mode |=> o_prdata == '0)
    else $error("special register visible in ISA mode");

  // Routing and refused accesses
  chk_unmapped_err: assert property (
    setup && !(aligned && hit_nxt) |=> o_pslverr && o_prdata == '0)
    else $error("unmapped access not refused");

  chk_ldn_write: assert property (
    wr_en && idx == IDX_LDN |=> ldn_r == $past(wd))
    else $error("device number write lost");

  chk_write_refused: assert property (
    i_psel && i_penable && i_pwrite && !(aligned && hit_nxt) |=> $stable(ldn_r) && $stable(uact_r)
      && $stable(urchk_r) && $stable(fspec_r) && $stable(uspec_r) && $stable(fdma_r))
    else $error("refused write changed a register");

  // Host I/O probe answers
  chk_range_aa: assert property (
    i_io_rd && io_hit[0] && !urchk_r[0][RCHK_PAT_BIT] |=> o_io_claim && o_io_rdata == RCHK_ANS_CLR)
    else $error("range check answer not aa");

  chk_io_idle: assert property (
    !i_io_rd |=> !o_io_claim && o_io_rdata == RST_ZERO)
    else $error("probe answer without a read");

  chk_io_addr_miss: assert property (
    i_io_rd && io_hit == 2'b00 |=> !o_io_claim)
    else $error("probe claimed outside any range");

  // Decoded outputs toward the function units
  chk_uart_enable: assert property (
    i_rstn |=> o_uart_cfg[0].enable == $past(uact_r[0][ACT_EN_BIT])
      && o_uart_cfg[1].enable == $past(uact_r[1][ACT_EN_BIT]))
    else $error("serial enable not decoded");

  cov_uart2_activate: cover property (wr_en && idx == IDX_ACT && un && wd[0]);
  cov_range_pattern: cover property (o_io_claim && o_io_rdata == 8'haa);
  cov_unmapped: cover property (o_pslverr && i_psel && i_penable);
  cov_mb_special: cover property (mb_mode && wr_en && idx == IDX_SPECIAL);
  cov_dma_none: cover property (fdma_r == 8'h04 && o_floppy_cfg.dma_req == 4'h0);

endmodule

/* logic/fscr_pkg.sv */
// Constants and carrier types of the floppy/serial configuration register bank.
// Assumes index/data configuration space reached over a 32-bit APB, one index per word.
// Contract
// - Per-device indexes follow the selected device number
// - First serial port 01h, second 02h
// - Interrupt type reads fixed 02h, edge
// - DMA field 0-3 channel, 4 none
// - Floppy special: bit3 sharing, bit2 swap
// - Floppy special: bit1 three-mode, bit0 protect
// - Serial activate bit0 enable, rest reserved
// - Range check answers 55h or AAh
// - Range check only in ISA mode
// - Base high: upper nibble zero, lower RW
// - Base low: bits 7-3 RW, 2-0 zero
// - Level 0 none, 3 and Bh valid
// - Serial 1 special: bit1 sharing, bit0 MIDI
// - Special registers only in motherboard mode
package fscr_pkg;

  // Bus geometry
  localparam int APB_AW = 10;
  localparam int DATA_W = 32;
  localparam int IDX_LSB = 2;
  localparam int IDX_W = 8;

  // Configuration indexes
  localparam logic [7:0] IDX_LDN = 8'h07;
  localparam logic [7:0] IDX_MODE = 8'h2f;
  localparam logic [7:0] IDX_ACT = 8'h30;
  localparam logic [7:0] IDX_RCHK = 8'h31;
  localparam logic [7:0] IDX_BASE_HI = 8'h60;
  localparam logic [7:0] IDX_BASE_LO = 8'h61;
  localparam logic [7:0] IDX_IRQ_LVL = 8'h70;
  localparam logic [7:0] IDX_IRQ_TYPE = 8'h71;
  localparam logic [7:0] IDX_DMA = 8'h74;
  localparam logic [7:0] IDX_SPECIAL = 8'hf0;

  // Logical device numbers
  localparam logic [7:0] LDN_FLOPPY = 8'h00;
  localparam logic [7:0] LDN_UART1 = 8'h01;
  localparam logic [7:0] LDN_UART2 = 8'h02;

  // Writable bit masks
  localparam logic [7:0] MASK_ACT = 8'h01;
  localparam logic [7:0] MASK_RCHK = 8'h03;
  localparam logic [7:0] MASK_BASE_HI = 8'h0f;
  localparam logic [7:0] MASK_BASE_LO = 8'hf8;
  localparam logic [7:0] MASK_IRQ_LVL = 8'h0f;
  localparam logic [7:0] MASK_DMA = 8'h07;
  localparam logic [7:0] MASK_FSPEC = 8'h0f;
  localparam logic [7:0] MASK_USPEC = 8'h03;
  localparam logic [7:0] MASK_MODE = 8'h01;

  // Reset values
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_U1_BASE_HI = 8'h03;
  localparam logic [7:0] RST_U2_BASE_HI = 8'h02;
  localparam logic [7:0] RST_BASE_LO = 8'hf8;
  localparam logic [7:0] RST_U1_IRQ = 8'h04;
  localparam logic [7:0] RST_U2_IRQ = 8'h03;
  localparam logic [7:0] RST_DMA = 8'h02;

  // Fixed values and field positions
  localparam logic [7:0] IRQ_TYPE_EDGE = 8'h02;
  localparam logic [7:0] RCHK_ANS_SET = 8'h55;
  localparam logic [7:0] RCHK_ANS_CLR = 8'haa;
  localparam int RCHK_EN_BIT = 1;
  localparam int RCHK_PAT_BIT = 0;
  localparam int ACT_EN_BIT = 0;
  localparam int MODE_MB_BIT = 0;
  localparam int FSPEC_SHARE = 3;
  localparam int FSPEC_SWAP = 2;
  localparam int FSPEC_3MODE = 1;
  localparam int FSPEC_WP = 0;
  localparam int USPEC_SHARE = 1;
  localparam int USPEC_MIDI = 0;
  localparam int UART_SPAN_BITS = 3;
  localparam logic [3:0] IRQ_FIRST = 4'h3;
  localparam logic [3:0] IRQ_LAST = 4'hb;
  localparam logic [2:0] DMA_LAST = 3'h3;
  localparam logic [2:0] DMA_NONE = 3'h4;

  // Decoded serial port settings
  typedef struct packed {
    logic enable;
    logic [15:0] base;
    logic [15:0] irq_line;
    logic irq_share;
    logic midi;
  } fscr_uart_cfg_t;

  // Decoded floppy settings
  typedef struct packed {
    logic [3:0] dma_req;
    logic irq_share;
    logic swap_ab;
    logic three_mode;
    logic wr_protect;
  } fscr_floppy_cfg_t;

endpackage

/* testbench/test_fscr_top.sv */
// Self-checking bench for the floppy/serial configuration register bank.
// Assumes fscr_top with a zero-wait APB slave and a one-cycle host I/O probe.
`timescale 1ns/10ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_fail++; \
  $display("CHECK FAILED at %0t: got %0h expected %0h", $time, (g), (e)); end end
module test_fscr_top import fscr_pkg::*; ;
  // Register table entry: device, index, reset value, value after writing ff
  typedef struct packed {logic [7:0] dev; logic [7:0] idx; logic [7:0] rst; logic [7:0] wexp;} fscr_reg_t;
  localparam fscr_reg_t TBL [16] = '{
    '{8'h01, 8'h30, 8'h00, 8'h01}, '{8'h01, 8'h31, 8'h00, 8'h03}, '{8'h01, 8'h60, 8'h03, 8'h0f},
    '{8'h01, 8'h61, 8'hf8, 8'hf8}, '{8'h01, 8'h70, 8'h04, 8'h0f}, '{8'h01, 8'h71, 8'h02, 8'h02},
    '{8'h01, 8'hf0, 8'h00, 8'h00}, '{8'h02, 8'h30, 8'h00, 8'h01}, '{8'h02, 8'h31, 8'h00, 8'h03},
    '{8'h02, 8'h60, 8'h02, 8'h0f}, '{8'h02, 8'h61, 8'hf8, 8'hf8}, '{8'h02, 8'h70, 8'h03, 8'h0f},
    '{8'h02, 8'h71, 8'h02, 8'h02}, '{8'h00, 8'h71, 8'h02, 8'h02}, '{8'h00, 8'h74, 8'h02, 8'h07},
    '{8'h00, 8'hf0, 8'h00, 8'h00}};
  // Bench drive and observe signals
  logic i_clk_sys = 1'b0;
  logic i_rstn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [APB_AW-1:0] paddr = '0;
  logic [DATA_W-1:0] pwdata = '0;
  logic io_rd = 1'b0;
  logic [15:0] io_addr = 16'h0000;
  logic o_pready;
  logic [DATA_W-1:0] o_prdata;
  logic o_pslverr;
  logic o_io_claim;
  logic [7:0] o_io_rdata;
  fscr_uart_cfg_t [1:0] o_uart_cfg;
  fscr_floppy_cfg_t o_floppy_cfg;
  logic [DATA_W-1:0] rd_v;
  logic err_v;
  logic [15:0] exp_line;
  logic [3:0] exp_dma;
  int n_fail = 0;
  int n_compared = 0;

  fscr_top i_dut (.i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(o_pready), .o_prdata(o_prdata),
    .o_pslverr(o_pslverr), .i_io_rd(io_rd), .i_io_addr(io_addr), .o_io_claim(o_io_claim),
    .o_io_rdata(o_io_rdata), .o_uart_cfg(o_uart_cfg), .o_floppy_cfg(o_floppy_cfg));

  // 40 MHz system clock
  initial begin
    forever #12.5 i_clk_sys = ~i_clk_sys;
  end

  // One APB transfer; response taken at the edge where pready is seen
  task automatic apb(input logic [APB_AW-1:0] a, input logic w, input logic [7:0] d);
    @(posedge i_clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge i_clk_sys);
    penable <= 1'b1;
    do @(posedge i_clk_sys); while (o_pready !== 1'b1);
    rd_v = o_prdata;
    err_v = o_pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    apb({idx, 2'b00}, 1'b1, d);
  endtask

  // Read and compare one index
  task automatic rd(input logic [7:0] idx, input logic [7:0] e);
    apb({idx, 2'b00}, 1'b0, 8'h00);
    `CHK(rd_v, {24'h000000, e})
  endtask

  // Let decoded outputs follow a write
  task automatic st;
    @(posedge i_clk_sys);
    #1;
  endtask

  // Host I/O read probe with expected answer one cycle later
  task automatic io(input logic [15:0] a, input logic c, input logic [7:0] d);
    @(posedge i_clk_sys);
    io_rd <= 1'b1;
    io_addr <= a;
    @(posedge i_clk_sys);
    io_rd <= 1'b0;
    #1;
    `CHK(o_io_claim, c)
    `CHK(o_io_rdata, d)
  endtask

  task automatic test_done;
    $display("compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Watchdog well beyond the expected few hundred cycles
  initial begin
    #(25 * 20000);
    n_fail++;
    test_done();
  end

  // Test sequence
  initial begin
    repeat (12) @(posedge i_clk_sys);
    i_rstn <= 1'b1;
    st();
    st();
    `CHK(o_uart_cfg[0].base, 16'h03f8)
    `CHK(o_uart_cfg[1].base, 16'h02f8)
    `CHK(o_uart_cfg[0].irq_line, 16'h0010)
    `CHK(o_uart_cfg[1].irq_line, 16'h0008)
    `CHK(o_floppy_cfg.dma_req, 4'h4)
    // Reset values, then masked write-all-ones readback per device
    for (int i = 0; i < 16; i++) begin
      wr(IDX_LDN, TBL[i].dev);
      rd(TBL[i].idx, TBL[i].rst);
      wr(TBL[i].idx, 8'hff);
      rd(TBL[i].idx, TBL[i].wexp);
      wr(TBL[i].idx, TBL[i].rst);
    end
    $display("test registers done");
    // Refused accesses: unmapped index and misaligned address
    wr(IDX_LDN, LDN_UART2);
    wr(IDX_SPECIAL, 8'h01);
    `CHK(err_v, 1'b1)
    apb(10'h015, 1'b0, 8'h00);
    `CHK(err_v, 1'b1)
    `CHK(rd_v, 32'h00000000)
    $display("test refusal done");
    // Interrupt level decode on the first serial port
    wr(IDX_LDN, LDN_UART1);
    for (int l = 0; l < 16; l++) begin
      wr(IDX_IRQ_LVL, 8'(l));
      st();
      exp_line = (l >= 3 && l <= 11) ? (16'h0001 << l) : 16'h0000;
      `CHK(o_uart_cfg[0].irq_line, exp_line)
    end
    rd(IDX_IRQ_LVL, 8'h0f);
    `CHK(o_uart_cfg[1].irq_line, 16'h0008)
    $display("test irq level done");
    // DMA select decode
    wr(IDX_LDN, LDN_FLOPPY);
    for (int l = 0; l < 8; l++) begin
      wr(IDX_DMA, 8'(l) | 8'hf8);
      st();
      exp_dma = (l < 4) ? (4'h1 << l) : 4'h0;
      `CHK(o_floppy_cfg.dma_req, exp_dma)
    end
    $display("test dma done");
    // Base address, enable and range-check answers
    wr(IDX_LDN, LDN_UART1);
    wr(IDX_BASE_HI, 8'hf2);
    wr(IDX_BASE_LO, 8'hef);
    wr(IDX_ACT, 8'hff);
    st();
    `CHK(o_uart_cfg[0].base, 16'h02e8)
    `CHK(o_uart_cfg[0].enable, 1'b1)
    wr(IDX_ACT, 8'h00);
    wr(IDX_RCHK, 8'h03);
    io(16'h02ef, 1'b1, 8'h55);
    io(16'h02e8, 1'b1, 8'h55);
    io(16'h02f0, 1'b0, 8'h00);
    io(16'h02f8, 1'b0, 8'h00);
    wr(IDX_RCHK, 8'h02);
    io(16'h02ea, 1'b1, 8'haa);
    wr(IDX_MODE, 8'h01);
    io(16'h02ea, 1'b0, 8'h00);
    // Second port: level seven and enable
    wr(IDX_LDN, LDN_UART2);
    wr(IDX_IRQ_LVL, 8'h07);
    wr(IDX_ACT, 8'h01);
    st();
    `CHK(o_uart_cfg[1].enable, 1'b1)
    `CHK(o_uart_cfg[1].irq_line, 16'h0080)
    `CHK(o_uart_cfg[0].enable, 1'b0)
    $display("test range check done");
    // Special registers in motherboard mode
    wr(IDX_LDN, LDN_FLOPPY);
    wr(IDX_SPECIAL, 8'hfa);
    st();
    rd(IDX_SPECIAL, 8'h0a);
    `CHK({o_floppy_cfg.irq_share, o_floppy_cfg.swap_ab}, 2'b10)
    `CHK({o_floppy_cfg.three_mode, o_floppy_cfg.wr_protect}, 2'b10)
    wr(IDX_SPECIAL, 8'h05);
    st();
    `CHK({o_floppy_cfg.irq_share, o_floppy_cfg.swap_ab}, 2'b01)
    `CHK({o_floppy_cfg.three_mode, o_floppy_cfg.wr_protect}, 2'b01)
    wr(IDX_LDN, LDN_UART1);
    wr(IDX_SPECIAL, 8'hfe);
    st();
    rd(IDX_SPECIAL, 8'h02);
    `CHK({o_uart_cfg[0].irq_share, o_uart_cfg[0].midi}, 2'b10)
    wr(IDX_SPECIAL, 8'h01);
    st();
    `CHK({o_uart_cfg[0].irq_share, o_uart_cfg[0].midi}, 2'b01)
    `CHK({o_uart_cfg[1].irq_share, o_uart_cfg[1].midi}, 2'b00)
    // Back to ISA mode hides the special settings
    wr(IDX_MODE, 8'h00);
    st();
    rd(IDX_SPECIAL, 8'h00);
    `CHK(o_uart_cfg[0].midi, 1'b0)
    `CHK(o_floppy_cfg.wr_protect, 1'b0)
    $display("test special done");
    test_done();
  end
endmodule
